// [logic/dsrtw_top.sv]
`timescale 1ns/100ps
// Contract
// - 24-bit word: bank, rw, channel, register, data
// - sync fall restarts count; extra clocks ignored
// - rw flag set requests readback of selected register
// - next frame shifts selected register out
// - readback: address in top ten, data below
// - output changes on rising serial clock edge
// - first readback bit stands at sync fall
// - select low: two-wire slave, never drives clock
// - slave address 10101 plus two pin bits
// - data change while clock high is control
// - start and stop detection; repeated start continues
// - acknowledge each byte by low ninth bit
// - write only: address byte lsb zero
// - idle until start plus matching address
// - address, pointer, two data bytes, stop
// - no stop: further pointer and data accepted
// - register select bits choose channel register
// - pointer 0xff: burst from channel 0, incrementing
// - stop anywhere ends mode, returns idle
// - burst writes never select alternate bank
module dsrtw_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic iface_sel,
  input wire logic serial_clk,
  input wire logic frame_sync_n,
  input wire logic serial_din,
  output logic serial_data_out,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_pin_hi,
  input wire logic addr_select_pin_lo,
  output logic tw_busy,
  output logic wr_stb,
  output logic wr_bank,
  output logic [dsrtw_pkg::CH_W-1:0] wr_chan,
  output logic [dsrtw_pkg::REG_W-1:0] wr_reg,
  output logic [dsrtw_pkg::DATA_W-1:0] wr_data,
  output logic rd_req,
  output logic [dsrtw_pkg::CH_W-1:0] rd_chan,
  output logic [dsrtw_pkg::REG_W-1:0] rd_reg,
  input wire logic [dsrtw_pkg::DATA_W-1:0] rd_data
);
  import dsrtw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // overview: two host ports share one write port towards the register
  // owner; the select pin picks the port that listens, the other is idle.
  // the framed port runs on the host's clock and only hands finished words
  // across. the two-wire port is sampled on the system clock through the
  // pin synchronisers, so its bit rate must stay far below the system
  // clock; a 400 kHz bus leaves over a hundred system clocks per phase
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  // synchroniser stages and edge history
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic done_d_reg;
  logic sel_spi;
  logic scl_s;
  logic sda_s;
  logic done_s;
  // framed port hand-over
  logic [FRAME_W-1:0] link_word;
  logic link_done;
  logic [DATA_W-1:0] rb_data_reg;
  logic rb_ok_reg;
  logic rd_fetch_reg;
  logic spi_evt;
  logic spi_rd;
  logic spi_wr;
  // two-wire line conditions
  logic tw_on;
  logic scl_rise;
  logic scl_fall;
  logic tw_start;
  logic tw_stop;
  logic byte_done;
  logic addr_hit;
  logic tw_wr;
  // two-wire receive state
  dsrtw_tw_state_e tw_state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] hi_reg;
  logic [CH_W-1:0] chan_reg;
  logic burst_reg;
  logic ptr_bank_reg;

  ////////////////////////////////////////////////////////////////////////////
  // link-clock side of the framed port; it only ticks inside frames, so
  // everything it hands over is a level or a word that stands still
  // limitation: with its clock stopped between frames the link side never
  // sees reset release on an edge, so its flops clear asynchronously
  dsrtw_link u_link (
    .serial_clk(serial_clk),
    .sys_rst(sys_rst),
    .frame_sync_n(frame_sync_n),
    .serial_din(serial_din),
    .rb_data(rb_data_reg),
    .rb_ok(rb_ok_reg),
    .frame_word(link_word),
    .frame_done(link_done),
    .serial_data_out(serial_data_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for every pin and for the frame-done level;
  // edge detection looks only at the second stage and its delayed copy
  // the preload equals idle pins (framed mode, both lines high), so no
  // false start, stop or frame edge follows reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_meta_reg <= PIN_IDLE;
      pin_sync_reg <= PIN_IDLE;
    end else if (clk_en) begin
      pin_meta_reg <= {link_done, sda_in, scl_in, addr_select_pin_lo,
                       addr_select_pin_hi, iface_sel};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // delayed copies for edge detection
  // reset values equal the idle levels, so reset makes no false edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_d_reg <= PIN_IDLE[PIN_SCL];
      sda_d_reg <= PIN_IDLE[PIN_SDA];
      done_d_reg <= PIN_IDLE[PIN_DONE];
    end else if (clk_en) begin
      scl_d_reg <= pin_sync_reg[PIN_SCL];
      sda_d_reg <= pin_sync_reg[PIN_SDA];
      done_d_reg <= pin_sync_reg[PIN_DONE];
    end
  end

  assign sel_spi = pin_sync_reg[PIN_SEL];
  assign scl_s = pin_sync_reg[PIN_SCL];
  assign sda_s = pin_sync_reg[PIN_SDA];
  assign done_s = pin_sync_reg[PIN_DONE];

  ////////////////////////////////////////////////////////////////////////////
  // framed port: one event per completed 24-bit frame
  // a frame cut short never raises the done level, so a partial word is
  // dropped without any further logic
  assign spi_evt = sel_spi & done_s & ~done_d_reg;
  assign spi_rd = spi_evt & link_word[RW_POS];
  // the all-zero frame only clocks readback out and writes nothing
  assign spi_wr = spi_evt & ~link_word[RW_POS] & (link_word != NOP_WORD);

  // read request towards the register owner, data taken one cycle later;
  // the ready level drops on every new frame so stale data is never sent
  // trade-off: one cycle of extra latency lets the register owner answer
  // from a plain synchronous memory
  // the owner must present rd_data in the cycle after rd_req
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_req <= 1'b0;
      rd_chan <= '0;
      rd_reg <= '0;
      rd_fetch_reg <= 1'b0;
      rb_data_reg <= '0;
      rb_ok_reg <= 1'b0;
    end else if (clk_en) begin
      rd_req <= spi_rd;
      rd_fetch_reg <= rd_req;
      if (spi_evt) begin
        rb_ok_reg <= 1'b0;
      end
      if (spi_rd) begin
        rd_chan <= link_word[CH_LSB +: CH_W];
        rd_reg <= link_word[REG_LSB +: REG_W];
      end
      if (rd_fetch_reg) begin
        rb_data_reg <= rd_data;
        rb_ok_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-wire bus conditions; a data change with the clock high is control
  // start and stop need the clock high before and after the data change,
  // so a data edge that meets a clock edge is never taken as control
  assign tw_on = ~sel_spi;
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign tw_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign tw_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign byte_done = scl_fall & (bit_cnt_reg == BYTE_DONE) & (tw_state_reg != TW_IDLE);
  // fixed upper bits, two pin bits, write direction only
  // limitation: no read path exists, so a read address is left
  // unanswered and the master sees no acknowledge
  assign addr_hit = (shift_reg[7:3] == SLAVE_FIXED)
                  & (shift_reg[2] == pin_sync_reg[PIN_AHI])
                  & (shift_reg[1] == pin_sync_reg[PIN_ALO])
                  & ~shift_reg[0];
  assign tw_wr = byte_done & (tw_state_reg == TW_LO);

  ////////////////////////////////////////////////////////////////////////////
  // two-wire receive state machine. bits are taken on rising clock edges;
  // the acknowledge is put on after the eighth falling edge and taken off
  // after the ninth, so the line only changes while the clock is low
  // states:
  //   idle - waits for a start and ignores every bit
  //   addr - collects the slave address and direction bit
  //   ptr  - collects the channel pointer or the burst code
  //   hi   - collects register select and upper data bits
  //   lo   - collects the lower data bits and fires the write
  // the bit counter runs 0..8 while a byte comes in and parks at 9 while
  // the acknowledge stands; the ninth falling edge returns it to 0
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tw_state_reg <= TW_IDLE;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      hi_reg <= '0;
      chan_reg <= '0;
      burst_reg <= 1'b0;
      ptr_bank_reg <= 1'b0;
      sda_oe <= 1'b0;
    end else if (clk_en) begin
      // framed mode selected: slave held idle, line released
      if (!tw_on) begin
        tw_state_reg <= TW_IDLE;
        bit_cnt_reg <= '0;
        burst_reg <= 1'b0;
        sda_oe <= 1'b0;
      end else if (tw_start) begin
        // a repeated start simply begins a new address phase
        tw_state_reg <= TW_ADDR;
        bit_cnt_reg <= '0;
        burst_reg <= 1'b0;
        sda_oe <= 1'b0;
      end else if (tw_stop) begin
        // a stop anywhere, even mid-byte, drops any pending mode
        tw_state_reg <= TW_IDLE;
        bit_cnt_reg <= '0;
        burst_reg <= 1'b0;
        sda_oe <= 1'b0;
      end else if (tw_state_reg != TW_IDLE) begin
        // shift the eight data bits only; the ninth is the acknowledge
        if (scl_rise && bit_cnt_reg < BYTE_DONE) begin
          shift_reg <= {shift_reg[6:0], sda_s};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        if (scl_fall && bit_cnt_reg == ACK_SLOT) begin
          sda_oe <= 1'b0; // ninth clock over, release the line
          bit_cnt_reg <= '0;
        end
        // eighth falling edge: byte complete, decide ack and next state
        if (byte_done) begin
          bit_cnt_reg <= ACK_SLOT;
          unique case (tw_state_reg)
            TW_IDLE: begin
              tw_state_reg <= TW_IDLE;
            end
            TW_ADDR: begin
              // no acknowledge and back to idle on a foreign address
              sda_oe <= addr_hit;
              tw_state_reg <= addr_hit ? TW_PTR : TW_IDLE;
            end
            TW_PTR: begin
              // a plain pointer carries bank and channel, the burst code neither
              sda_oe <= 1'b1;
              tw_state_reg <= TW_HI;
              if (shift_reg == BURST_PTR) begin
                burst_reg <= 1'b1;
                chan_reg <= BURST_CH0;
              end else begin
                burst_reg <= 1'b0;
                chan_reg <= shift_reg[CH_W-1:0];
                ptr_bank_reg <= shift_reg[PTR_BANK_POS];
              end
            end
            TW_HI: begin
              // kept until the lower byte completes the word
              sda_oe <= 1'b1;
              hi_reg <= shift_reg;
              tw_state_reg <= TW_LO;
            end
            TW_LO: begin
              // burst walks the channels, otherwise a new pointer is due
              sda_oe <= 1'b1;
              if (burst_reg) begin
                chan_reg <= chan_reg + 6'h01;
                tw_state_reg <= TW_HI;
              end else begin
                tw_state_reg <= TW_PTR;
              end
            end
          endcase
        end
      end
    end
  end

  // data line is only ever pulled low; the clock line has no driver at all
  // hazard: driving the line high would fight other open-drain devices,
  // so only the enable ever moves
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sda_out <= 1'b0;
      tw_busy <= 1'b0;
    end else if (clk_en) begin
      sda_out <= 1'b0;
      tw_busy <= tw_on & (tw_state_reg != TW_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write port shared by both interfaces; the select pin makes them
  // exclusive, the framed port still wins should both fire together
  // pairing: upper byte bits 7:6 pick the register, its bits 5:0 and the
  // whole lower byte form the 14-bit value
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_stb <= 1'b0;
      wr_bank <= 1'b0;
      wr_chan <= '0;
      wr_reg <= '0;
      wr_data <= '0;
    end else if (clk_en) begin
      wr_stb <= spi_wr | tw_wr;
      if (spi_wr) begin
        wr_bank <= link_word[BANK_POS];
        wr_chan <= link_word[CH_LSB +: CH_W];
        wr_reg <= link_word[REG_LSB +: REG_W];
        wr_data <= link_word[DATA_W-1:0];
      end else if (tw_wr) begin
        wr_bank <= burst_reg ? 1'b0 : ptr_bank_reg;
        wr_chan <= chan_reg;
        wr_reg <= hi_reg[7:6];
        wr_data <= {hi_reg[5:0], shift_reg};
      end
    end
  end

endmodule : dsrtw_top

// [logic/dsrtw_pkg.sv]
package dsrtw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // framed serial word layout, msb first
  localparam int FRAME_W = 24;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_CNT = 5'h18;
  localparam logic [CNT_W-1:0] LAST_BIT = 5'h17;
  localparam int BANK_POS = 23;
  localparam int RW_POS = 22;
  localparam int CH_LSB = 16;
  localparam int CH_W = 6;
  localparam int REG_LSB = 14;
  localparam int REG_W = 2;
  localparam int DATA_W = 14;
  localparam int HDR_W = 10;
  localparam logic [FRAME_W-1:0] NOP_WORD = 24'h000000;

  ////////////////////////////////////////////////////////////////////////////
  // two-wire slave constants
  localparam logic [4:0] SLAVE_FIXED = 5'h15;
  localparam logic [7:0] BURST_PTR = 8'hff;
  localparam logic [3:0] BYTE_DONE = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;
  localparam int PTR_BANK_POS = 7;
  localparam logic [CH_W-1:0] BURST_CH0 = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser layout and idle/reset value
  localparam int PIN_W = 6;
  localparam int PIN_SEL = 0;
  localparam int PIN_AHI = 1;
  localparam int PIN_ALO = 2;
  localparam int PIN_SCL = 3;
  localparam int PIN_SDA = 4;
  localparam int PIN_DONE = 5;
  localparam logic [PIN_W-1:0] PIN_IDLE = 6'h19;

  typedef enum logic [4:0] {
    TW_IDLE = 5'h01,
    TW_ADDR = 5'h02,
    TW_PTR = 5'h04,
    TW_HI = 5'h08,
    TW_LO = 5'h10
  } dsrtw_tw_state_e;

endpackage : dsrtw_pkg

// [logic/dsrtw_link.sv]
`timescale 1ns/100ps
module dsrtw_link (
  input wire logic serial_clk,
  input wire logic sys_rst,
  input wire logic frame_sync_n,
  input wire logic serial_din,
  input wire logic [dsrtw_pkg::DATA_W-1:0] rb_data,
  input wire logic rb_ok,
  output logic [dsrtw_pkg::FRAME_W-1:0] frame_word,
  output logic frame_done,
  output logic serial_data_out
);
  import dsrtw_pkg::*;

  logic [CNT_W-1:0] bit_cnt_reg;
  logic [HDR_W-1:0] hdr_reg;
  logic rd_arm_reg;
  logic ok_meta_reg;
  logic ok_sync_reg;
  logic [FRAME_W-1:0] rb_word;

  ////////////////////////////////////////////////////////////////////////////
  // bit counter: held at zero while the frame sync is high, so its fall
  // restarts counting; it stops at 24 and ignores extra clocks
  always_ff @(negedge serial_clk or posedge frame_sync_n or posedge sys_rst) begin
    if (frame_sync_n || sys_rst) begin
      bit_cnt_reg <= '0;
      frame_done <= 1'b0;
    end else if (bit_cnt_reg != FRAME_CNT) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      if (bit_cnt_reg == LAST_BIT) begin
        frame_done <= 1'b1; // level, crossed by the system side
      end
    end
  end

  // input shifter, msb first; frozen once the word is complete
  always_ff @(negedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_word <= '0;
    end else if (!frame_sync_n && bit_cnt_reg != FRAME_CNT) begin
      frame_word <= {frame_word[FRAME_W-2:0], serial_din};
    end
  end

  // readback data ready level from the system domain
  always_ff @(posedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ok_meta_reg <= 1'b0;
      ok_sync_reg <= 1'b0;
    end else begin
      ok_meta_reg <= rb_ok;
      ok_sync_reg <= ok_meta_reg;
    end
  end

  // upper ten bits echo the request, low bits carry the register value
  assign rb_word = {hdr_reg, ok_sync_reg ? rb_data : {DATA_W{1'b0}}};

  ////////////////////////////////////////////////////////////////////////////
  // output driver changes on rising edges. the first bit is put out on the
  // rising edge that closes the request frame, so it already stands when the
  // next frame sync falls with the clock idling high
  always_ff @(posedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hdr_reg <= '0;
      rd_arm_reg <= 1'b0;
      serial_data_out <= 1'b0;
    end else if (!frame_sync_n && bit_cnt_reg == FRAME_CNT) begin
      rd_arm_reg <= frame_word[RW_POS];
      hdr_reg <= frame_word[FRAME_W-1 -: HDR_W];
      serial_data_out <= frame_word[RW_POS] & frame_word[BANK_POS];
    end else if (!frame_sync_n && bit_cnt_reg != 5'h00) begin
      serial_data_out <= rd_arm_reg & rb_word[LAST_BIT - bit_cnt_reg];
    end
  end

endmodule : dsrtw_link

// [sim/dsrtw_top_chk.sv]
`timescale 1ns/100ps
module dsrtw_top_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic iface_sel,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic tw_busy,
  input wire logic wr_stb,
  input wire logic wr_bank,
  input wire logic [dsrtw_pkg::CH_W-1:0] wr_chan,
  input wire logic [dsrtw_pkg::REG_W-1:0] wr_reg,
  input wire logic [dsrtw_pkg::DATA_W-1:0] wr_data,
  input wire logic rd_req,
  input wire logic [dsrtw_pkg::CH_W-1:0] rd_chan,
  input wire logic [dsrtw_pkg::REG_W-1:0] rd_reg
);
  import dsrtw_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  // one strobe per accepted write, fields frozen between strobes
  property p_wr_pulse; wr_stb |=> !wr_stb; endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe longer than one cycle");
  property p_wr_hold; !wr_stb |-> $stable({wr_bank, wr_chan, wr_reg, wr_data}); endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write fields moved without a strobe");
  property p_rd_hold; !rd_req |-> $stable({rd_chan, rd_reg}); endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read select moved without a request");
  // framed mode must leave the data line alone
  property p_sel_quiet; iface_sel [*8] |-> !sda_oe; endproperty
  a_sel_quiet: assert property (p_sel_quiet)
    else $error("data line driven in framed mode");
  // the ack may only move while the clock line is low, else it reads as start or stop
  property p_oe_scl_low; $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2); endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("ack edge while clock high");
  property p_ack_len; $rose(sda_oe) |-> sda_oe throughout (##[1:300] $fell(scl_in)); endproperty
  a_ack_len: assert property (p_ack_len)
    else $error("ack released before ninth clock ended");
  property p_stop_idle; scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:8] !tw_busy; endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not return slave to idle");
  property p_oe_busy; $rose(sda_oe) |-> tw_busy; endproperty
  a_oe_busy: assert property (p_oe_busy)
    else $error("ack while slave idle");
endmodule : dsrtw_top_chk

bind dsrtw_top dsrtw_top_chk u_chk (.sys_clk, .sys_rst, .iface_sel, .scl_in, .sda_in,
  .sda_oe, .tw_busy, .wr_stb, .wr_bank, .wr_chan, .wr_reg, .wr_data, .rd_req,
  .rd_chan, .rd_reg);

// [sim/dsrtw_host.sv]
`timescale 1ns/100ps
module dsrtw_host (
  output logic serial_clk,
  output logic frame_sync_n,
  output logic serial_din,
  input wire logic serial_data_out,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam int HALF = 24;
  localparam int Q = 625; // quarter of a 400 kHz bus period
  logic [23:0] rx;
  ////////////////////////////////////////////////////////////////////////////
  // idle bus: link clock parked high, both two-wire lines released
  initial begin
    serial_clk = 1'b1;
    frame_sync_n = 1'b1;
    serial_din = 1'b0;
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // msb first; din moves after a rise, readback sampled on each fall
  task automatic frame(input logic [23:0] w, input int n);
    frame_sync_n = 1'b0;
    #HALF;
    for (int i = 0; i < n; i++) begin
      serial_din = (i < 24) ? w[23-i] : ~serial_din;
      #HALF serial_clk = 1'b0;
      if (i < 24) rx[23-i] = serial_data_out;
      #HALF serial_clk = 1'b1;
    end
    #HALF frame_sync_n = 1'b1;
    serial_din = ~serial_din; // no stale value between frames
    #200;
  endtask : frame
  // data only changes while the clock is low
  task automatic bit_out(input logic b, output logic seen);
    sda_low = ~b;
    #Q scl = 1'b1;
    #Q seen = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : bit_out
  // eight bits, then a released ninth bit where the slave may ack
  task automatic tw_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_out(b[i], s);
    bit_out(1'b1, s);
    ack = ~s;
  endtask : tw_byte
  // start or repeated start: data falls with clock high
  task automatic tw_start();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask : tw_start
  // stop: data rises with clock high
  task automatic tw_stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #(2*Q);
  endtask : tw_stop
endmodule : dsrtw_host

// [sim/dsrtw_top_tb.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module dsrtw_top_tb;
  import dsrtw_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b0;
  logic iface_sel = 1'b1;
  logic addr_select_pin_hi = 1'b1;
  logic addr_select_pin_lo = 1'b0;
  logic [DATA_W-1:0] rd_data = 14'h0000;
  logic serial_clk, frame_sync_n, serial_din, serial_data_out, scl_in, sda_low;
  logic sda_out, sda_oe, tw_busy, wr_stb, wr_bank, rd_req;
  logic [CH_W-1:0] wr_chan, rd_chan, c;
  logic [REG_W-1:0] wr_reg, rd_reg, r;
  logic [DATA_W-1:0] wr_data;
  logic [22:0] last_wr;
  logic [23:0] w;
  wire sda = ~(sda_low | (sda_oe & ~sda_out)); // open drain with pull-up
  int comparisons = 0;
  int n_mismatch = 0;
  int n_wr = 0;
  int n_rd = 0;
  int n0;
  dsrtw_top dut (.sys_clk, .sys_rst, .clk_en(1'b1), .iface_sel, .serial_clk, .frame_sync_n,
    .serial_din, .serial_data_out, .scl_in, .sda_in(sda), .sda_out, .sda_oe,
    .addr_select_pin_hi, .addr_select_pin_lo, .tw_busy, .wr_stb, .wr_bank, .wr_chan,
    .wr_reg, .wr_data, .rd_req, .rd_chan, .rd_reg, .rd_data);
  dsrtw_host host (.serial_clk, .frame_sync_n, .serial_din, .serial_data_out,
    .scl(scl_in), .sda_low, .sda);
  ////////////////////////////////////////////////////////////////////////////
  always #5 sys_clk = ~sys_clk;
  // register store stand-in plus a log of every write strobe
  always @(posedge sys_clk) begin
    if (rd_req) begin
      rd_data <= {rd_reg, rd_chan, ~rd_chan};
      n_rd <= n_rd + 1;
    end
    if (wr_stb) begin
      n_wr <= n_wr + 1;
      last_wr <= {wr_bank, wr_chan, wr_reg, wr_data};
    end
  end
  task automatic end_of_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic fw(input logic [23:0] fr, input int n, input int dn, input logic [22:0] e);
    int m0;
    m0 = n_wr;
    host.frame(fr, n);
    `CHK(n_wr - m0, dn)
    if (dn > 0) `CHK(last_wr, e)
  endtask : fw
  task automatic twb(input logic [7:0] b, input logic e);
    logic a;
    host.tw_byte(b, a);
    `CHK(a, e)
  endtask : twb
  task automatic tww(input logic [7:0] hi, input logic [7:0] lo, input logic [22:0] e);
    n0 = n_wr;
    twb(hi, 1'b1);
    twb(lo, 1'b1);
    `CHK(n_wr - n0, 1)
    `CHK(last_wr, e)
  endtask : tww
  // a hang costs at most this long; the full run needs roughly 0.55 ms
  initial begin
    #900000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    // raised by an update so the link flops see a rising edge and clear
    sys_rst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // surplus clocks ignored, a cut frame and the all-zero frame write nothing
    fw({1'b1, 1'b0, 6'h2a, 2'h2, 14'h1234}, 28, 1, {1'b1, 6'h2a, 2'h2, 14'h1234});
    fw({1'b0, 1'b0, 6'h05, 2'h1, 14'h3fff}, 12, 0, 23'h0);
    fw(NOP_WORD, 24, 0, 23'h0);
    // readback request then an all-zero frame that carries the answer out
    for (int k = 0; k < 2; k++) begin
      c = k ? 6'h27 : 6'h00;
      r = k ? 2'h3 : 2'h1;
      w = {k[0], 1'b1, c, r, 14'h2aaa};
      n0 = n_rd;
      fw(w, 24, 0, 23'h0);
      `CHK(n_rd - n0, 1)
      `CHK({rd_chan, rd_reg}, {c, r})
      host.frame(NOP_WORD, 24);
      `CHK(host.rx, {w[23:14], r, c, ~c})
    end
    @(posedge sys_clk);
    iface_sel <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // single channel, then another channel without a new address
    host.tw_start();
    twb({SLAVE_FIXED, 2'b10, 1'b0}, 1'b1);
    `CHK(tw_busy, 1'b1)
    twb(8'h85, 1'b1);
    tww(8'h92, 8'h34, {1'b1, 6'h05, 2'h2, 14'h1234});
    twb(8'hbf, 1'b1);
    tww(8'h40, 8'h01, {1'b1, 6'h3f, 2'h1, 14'h0001});
    // repeated start into burst: channels count up from zero, bank forced low
    host.tw_start();
    twb({SLAVE_FIXED, 2'b10, 1'b0}, 1'b1);
    twb(BURST_PTR, 1'b1);
    for (int k = 0; k < 3; k++)
      tww(8'hc0, k[7:0], {1'b0, k[5:0], 2'h3, 6'h00, k[7:0]});
    host.tw_stop();
    `CHK(tw_busy, 1'b0)
    n0 = n_wr;
    twb(8'hc0, 1'b0);
    twb(8'h11, 1'b0);
    `CHK(n_wr - n0, 0)
    // foreign address and a read request both go unanswered
    host.tw_start();
    twb({SLAVE_FIXED, 2'b01, 1'b0}, 1'b0);
    `CHK(tw_busy, 1'b0)
    host.tw_start();
    twb({SLAVE_FIXED, 2'b10, 1'b1}, 1'b0);
    host.tw_stop();
    @(posedge sys_clk);
    addr_select_pin_lo <= 1'b1;
    repeat (4) @(posedge sys_clk);
    host.tw_start();
    twb({SLAVE_FIXED, 2'b11, 1'b0}, 1'b1);
    twb(8'h01, 1'b1);
    tww(8'h3f, 8'hff, {1'b0, 6'h01, 2'h0, 14'h3fff});
    host.tw_stop();
    end_of_test();
  end
endmodule : dsrtw_top_tb
